/* shared/hbs_pkg.sv */
/*
 Package for the host buffer status register bank: command codes,
 field positions, reset values and carrier structs.
 Assumes a 16-bit command/data port from the local microprocessor.
*/
package hbs_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SPARE_RD = 8'h28;
    localparam logic [7:0] CMD_SPARE_WR = 8'ha8;
    localparam logic [7:0] CMD_RESET_WR = 8'ha9;
    localparam logic [7:0] CMD_STATUS_RD = 8'h2c;
    localparam logic [7:0] CMD_STATUS_WR = 8'hac;

    // ----------------------------------------------------------------
    // Values and field positions
    // ----------------------------------------------------------------
    localparam logic [15:0] RESET_KEY_VALUE = 16'h00f6;
    localparam logic [15:0] SPARE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam int BIT_ISO_A_FULL = 0;
    localparam int BIT_ISO_B_FULL = 1;
    localparam int BIT_INT_LIST_EN = 2;
    localparam int BIT_ASYNC_EN = 3;
    localparam int BIT_CLEAR_HALF = 4;
    localparam int BIT_ISO_A_IN_USE = 5;
    localparam int BIT_ISO_B_IN_USE = 6;
    localparam int BIT_ISO_A_DONE = 8;
    localparam int BIT_ISO_B_DONE = 9;
    localparam int BIT_HALF_SELECT = 10;

    // Command port request
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] wdata;
    } hbs_cmd_s;

    // Hardware status inputs from the transfer engine
    typedef struct packed {
        logic iso_buf_a_read_done;
        logic iso_buf_b_read_done;
        logic iso_buf_a_in_use;
        logic iso_buf_b_in_use;
        logic half_toggle;
        logic port_eot;
    } hbs_hw_s;

endpackage : hbs_pkg

/* src/hbs_rise_detect.sv */
/*
 Rising-edge detector for a written control bit.
 Assumes the input is on the same clock.
*/
`timescale 1ns/1ps
module hbs_rise_detect (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_rise
);

    logic last_reg;

    // Previous level
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= i_level;
        end
    end

    assign o_rise = i_level & ~last_reg;

endmodule : hbs_rise_detect

/* src/hbs_buffer_status_regs.sv */
/*
 Spare word, software reset key and transfer buffer status registers.
 Assumes command requests and hardware status inputs on i_ref_clk;
 buffer memory lives outside and is never reset here.
*/
//
// Contract
// R1: Sixteen-bit spare word, stores only, resets zero
// R2: Key F6h resets all registers, memory kept
// R3: Reset register write-only, reads zero, others ignored
// R4: Status read 2C, written AC, same register
// R5: Bit 10 shows descriptor half select
// R6: Bits 9,8 show iso buffer read done
// R7: Bits 6,5 show iso buffer in use
// R8: Bit 4 rising, async off, clears select
// R9: Bit 4 falling has no effect
// R10: Bit 3 enables async list processing
// R11: Bit 2 enables interrupt list processing
// R12: Bits 1,0 mark iso buffers full
// R13: Port transfer end flags EOT, updates status
// R14: Reserved status bits read zero, writes ignored
`timescale 1ns/1ps
module hbs_buffer_status_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire hbs_pkg::hbs_cmd_s i_cmd,
    input wire hbs_pkg::hbs_hw_s i_hw,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_soft_reset,
    output logic o_eot_flag,
    output logic o_async_list_process_en,
    output logic o_periodic_int_list_process_en,
    output logic o_iso_buf_a_full,
    output logic o_iso_buf_b_full,
    output logic o_paired_descriptor_half_select
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] spare_software_word_reg;
    logic [4:0] ctrl_reg;
    logic half_select_reg;
    logic [3:0] hw_stat_reg;
    logic soft_reset_reg;
    logic eot_reg;
    logic clear_rise;
    logic any_reset;
    logic wr_status;
    logic [15:0] status_view;

    assign any_reset = i_rst | soft_reset_reg; // R2
    assign wr_status = i_cmd.valid && i_cmd.code == hbs_pkg::CMD_STATUS_WR; // R4

    // ----------------------------------------------------------------
    // Software reset key
    // ----------------------------------------------------------------
    // One-cycle internal reset on the key value
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= i_cmd.valid && i_cmd.code == hbs_pkg::CMD_RESET_WR &&
                i_cmd.wdata == hbs_pkg::RESET_KEY_VALUE; // R2 R3
        end
    end

    // ----------------------------------------------------------------
    // Spare word
    // ----------------------------------------------------------------
    // Plain storage
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            spare_software_word_reg <= hbs_pkg::SPARE_RESET;
        end else if (i_cmd.valid && i_cmd.code == hbs_pkg::CMD_SPARE_WR) begin
            spare_software_word_reg <= i_cmd.wdata; // R1
        end
    end

    // ----------------------------------------------------------------
    // Writable status bits 4..0
    // ----------------------------------------------------------------
    // Control field write, reserved bits dropped
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            ctrl_reg <= hbs_pkg::STATUS_RESET[4:0];
        end else if (wr_status) begin
            ctrl_reg <= i_cmd.wdata[4:0]; // R10 R11 R12 R14
        end
    end

    // Detect clear bit going high
    hbs_rise_detect u_clear_rise (
        .i_ref_clk(i_ref_clk),
        .i_rst(any_reset),
        .i_level(ctrl_reg[hbs_pkg::BIT_CLEAR_HALF]),
        .o_rise(clear_rise)
    );

    // Descriptor half selector; clear only on rise with async off
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            half_select_reg <= hbs_pkg::STATUS_RESET[hbs_pkg::BIT_HALF_SELECT];
        end else if (clear_rise && !ctrl_reg[hbs_pkg::BIT_ASYNC_EN]) begin
            half_select_reg <= 1'b0; // R8 R9
        end else if (i_hw.half_toggle) begin
            half_select_reg <= ~half_select_reg; // R5
        end
    end

    // ----------------------------------------------------------------
    // Hardware status capture
    // ----------------------------------------------------------------
    // Read-done and in-use flags sampled from the engine
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            hw_stat_reg <= 4'h0;
        end else begin
            hw_stat_reg <= {i_hw.iso_buf_b_read_done, i_hw.iso_buf_a_read_done,
                i_hw.iso_buf_b_in_use, i_hw.iso_buf_a_in_use}; // R6 R7 R13
        end
    end

    // End-of-transfer flag, set wins over reset-free clear by status read
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            eot_reg <= 1'b0;
        end else if (i_hw.port_eot) begin
            eot_reg <= 1'b1; // R13
        end else if (i_cmd.valid && i_cmd.code == hbs_pkg::CMD_STATUS_RD) begin
            eot_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Status word assembly, reserved bits zero
    always_comb begin
        status_view = 16'h0000; // R14
        status_view[4:0] = ctrl_reg;
        status_view[hbs_pkg::BIT_ISO_A_IN_USE] = hw_stat_reg[0]; // R7
        status_view[hbs_pkg::BIT_ISO_B_IN_USE] = hw_stat_reg[1];
        status_view[hbs_pkg::BIT_ISO_A_DONE] = hw_stat_reg[2]; // R6
        status_view[hbs_pkg::BIT_ISO_B_DONE] = hw_stat_reg[3];
        status_view[hbs_pkg::BIT_HALF_SELECT] = half_select_reg; // R5
    end

    // Registered read answer
    always_ff @(posedge i_ref_clk) begin
        if (any_reset) begin
            o_rdata <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_cmd.valid && (i_cmd.code == hbs_pkg::CMD_SPARE_RD ||
                i_cmd.code == hbs_pkg::CMD_STATUS_RD);
            if (i_cmd.valid && i_cmd.code == hbs_pkg::CMD_SPARE_RD) begin
                o_rdata <= spare_software_word_reg; // R1
            end else if (i_cmd.valid && i_cmd.code == hbs_pkg::CMD_STATUS_RD) begin
                o_rdata <= status_view; // R4
            end else begin
                o_rdata <= 16'h0000; // R3
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Mirrors for the transfer engine
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_soft_reset <= 1'b0;
            o_eot_flag <= 1'b0;
            o_async_list_process_en <= 1'b0;
            o_periodic_int_list_process_en <= 1'b0;
            o_iso_buf_a_full <= 1'b0;
            o_iso_buf_b_full <= 1'b0;
            o_paired_descriptor_half_select <= 1'b0;
        end else begin
            o_soft_reset <= soft_reset_reg; // R2
            o_eot_flag <= eot_reg;
            o_async_list_process_en <= ctrl_reg[hbs_pkg::BIT_ASYNC_EN]; // R10
            o_periodic_int_list_process_en <= ctrl_reg[hbs_pkg::BIT_INT_LIST_EN]; // R11
            o_iso_buf_a_full <= ctrl_reg[hbs_pkg::BIT_ISO_A_FULL]; // R12
            o_iso_buf_b_full <= ctrl_reg[hbs_pkg::BIT_ISO_B_FULL];
            o_paired_descriptor_half_select <= half_select_reg;
        end
    end

endmodule : hbs_buffer_status_regs

/* testbench/hbs_regs_monitor.sv */
/* Port checker for the buffer status bank.
 Bound to the design top; sees its ports only. */
`timescale 1ns/1ps
module hbs_regs_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire hbs_pkg::hbs_cmd_s i_cmd,
    input wire hbs_pkg::hbs_hw_s i_hw,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_soft_reset,
    input wire logic o_eot_flag,
    input wire logic o_async_list_process_en,
    input wire logic o_periodic_int_list_process_en,
    input wire logic o_iso_buf_a_full,
    input wire logic o_iso_buf_b_full,
    input wire logic o_paired_descriptor_half_select
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic rd;
    logic key;
    // Decoded read and reset key requests
    assign rd = i_cmd.valid && (i_cmd.code == hbs_pkg::CMD_SPARE_RD || i_cmd.code == hbs_pkg::CMD_STATUS_RD);
    assign key = i_cmd.valid && i_cmd.code == hbs_pkg::CMD_RESET_WR;
    rd_answer_a: assert property (rd |=> o_rvalid) else $error("read not answered");
    no_answer_a: assert property (!rd |=> !o_rvalid) else $error("answer without read");
    rsv_zero_a: assert property (o_rvalid && $past(i_cmd.code) == hbs_pkg::CMD_STATUS_RD
        |-> o_rdata[15:11] == 5'h00 && !o_rdata[7]) else $error("reserved bit set");
    ctrl_bits_a: assert property (i_cmd.valid && i_cmd.code == hbs_pkg::CMD_STATUS_WR |-> ##2
        {o_async_list_process_en, o_periodic_int_list_process_en, o_iso_buf_b_full, o_iso_buf_a_full}
        == $past(i_cmd.wdata[3:0], 2)) else $error("control bits wrong");
    key_reset_a: assert property (key && i_cmd.wdata == hbs_pkg::RESET_KEY_VALUE |-> ##2 o_soft_reset)
        else $error("key did not reset");
    bad_key_a: assert property (key && i_cmd.wdata != hbs_pkg::RESET_KEY_VALUE |-> ##2 !o_soft_reset)
        else $error("wrong key reset");
    sel_toggle_a: assert property (i_hw.half_toggle && !i_cmd.valid && !$past(i_cmd.valid) ##1 !i_cmd.valid
        |=> o_paired_descriptor_half_select != $past(o_paired_descriptor_half_select)) else $error("no toggle");
    eot_set_a: assert property (i_hw.port_eot |-> ##[1:2] o_eot_flag) else $error("end flag missing");
    cover property (o_rvalid);
    cover property (o_soft_reset);
    cover property (o_eot_flag && o_iso_buf_b_full);
endmodule : hbs_regs_monitor
bind hbs_buffer_status_regs hbs_regs_monitor i_hbs_regs_monitor (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_cmd(i_cmd), .i_hw(i_hw), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_soft_reset(o_soft_reset),
    .o_eot_flag(o_eot_flag), .o_async_list_process_en(o_async_list_process_en),
    .o_periodic_int_list_process_en(o_periodic_int_list_process_en), .o_iso_buf_a_full(o_iso_buf_a_full),
    .o_iso_buf_b_full(o_iso_buf_b_full), .o_paired_descriptor_half_select(o_paired_descriptor_half_select));

/* testbench/hbs_engine_model.sv */
/* Transfer engine model: reads full iso buffers, flips the half select.
 Assumes the bank's control outputs on the same clock. */
`timescale 1ns/1ps
module hbs_engine_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_full,
    input wire logic i_async_en,
    output hbs_pkg::hbs_hw_s o_hw
);
    logic [1:0] use_reg;
    logic [1:0] done_reg;
    logic [2:0] cnt_reg [2];
    logic [2:0] tcnt_reg;
    logic eot_reg;
    // A full buffer is in use for seven cycles, then done
    always_ff @(posedge i_ref_clk) begin
        eot_reg <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (i_rst || !i_full[i]) begin
                use_reg[i] <= 1'b0;
                done_reg[i] <= 1'b0;
                cnt_reg[i] <= 3'h0;
            end else if (!done_reg[i]) begin
                use_reg[i] <= cnt_reg[i] != 3'h7;
                done_reg[i] <= cnt_reg[i] == 3'h7;
                cnt_reg[i] <= cnt_reg[i] + 3'h1;
                if (cnt_reg[i] == 3'h7) eot_reg <= 1'b1;
            end
        end
    end
    // Half select pulse every eighth cycle while async list runs
    always_ff @(posedge i_ref_clk) tcnt_reg <= (i_rst || !i_async_en) ? 3'h0 : tcnt_reg + 3'h1;
    assign o_hw = {done_reg[0], done_reg[1], use_reg[0], use_reg[1], i_async_en && tcnt_reg == 3'h7, eot_reg};
endmodule : hbs_engine_model

/* testbench/tb_hbs_buffer_status_regs.sv */
/* Bench for the buffer status bank: command tasks and checked sequences.
 Assumes the engine model on the hardware status side. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_hbs_buffer_status_regs;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    hbs_pkg::hbs_cmd_s cmd = '0;
    hbs_pkg::hbs_hw_s hw;
    logic [15:0] rdata;
    logic rvalid, srst, eot, aen, ien, fa, fb, sel;
    int error_cnt = 0;
    int n_tests = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    hbs_buffer_status_regs i_hbs_buffer_status_regs (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd(cmd), .i_hw(hw),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_soft_reset(srst), .o_eot_flag(eot), .o_async_list_process_en(aen),
        .o_periodic_int_list_process_en(ien), .o_iso_buf_a_full(fa), .o_iso_buf_b_full(fb),
        .o_paired_descriptor_half_select(sel));
    hbs_engine_model i_hbs_engine_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_full({fb, fa}),
        .i_async_en(aen), .o_hw(hw));
    // One command cycle, then wait n edges
    task automatic put(input logic [7:0] c, input logic [15:0] d, input int n = 0);
        cmd <= '{1'b1, c, d};
        @(posedge i_ref_clk);
        cmd.valid <= 1'b0;
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : put
    task automatic rd(input logic [7:0] c, input logic [15:0] e, input string nm);
        put(c, 16'h0000);
        `CHK(nm, 1'b1, rvalid)
        `CHK(nm, e, rdata)
    endtask : rd
    task automatic stop_test;
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        repeat (8) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        rd(hbs_pkg::CMD_SPARE_RD, 16'h0000, "spare");
        rd(hbs_pkg::CMD_STATUS_RD, 16'h0000, "status");
        put(hbs_pkg::CMD_SPARE_WR, 16'ha5c3, 1);
        rd(hbs_pkg::CMD_SPARE_RD, 16'ha5c3, "spare");
        $display("test spare done");
        put(hbs_pkg::CMD_STATUS_WR, 16'hff1c, 1);
        `CHK("aen", 1'b1, aen)
        `CHK("ien", 1'b1, ien)
        rd(hbs_pkg::CMD_STATUS_RD, 16'h001c, "status");
        for (int i = 0; i < 20 && sel !== 1'b1; i++) begin
            @(posedge i_ref_clk);
            #1;
        end
        put(hbs_pkg::CMD_STATUS_WR, 16'h0004, 2);
        rd(hbs_pkg::CMD_STATUS_RD, 16'h0404, "select");
        put(hbs_pkg::CMD_STATUS_WR, 16'h0014, 2);
        `CHK("sel", 1'b0, sel)
        rd(hbs_pkg::CMD_STATUS_RD, 16'h0014, "select");
        $display("test select done");
        for (int i = 0; i < 2; i++) begin
            put(hbs_pkg::CMD_STATUS_WR, 16'h0001 << i, 3);
            rd(hbs_pkg::CMD_STATUS_RD, 16'h0021 << i, "in use");
            for (int j = 0; j < 30 && eot !== 1'b1; j++) put(hbs_pkg::CMD_SPARE_RD, 16'h0000);
            rd(hbs_pkg::CMD_STATUS_RD, 16'h0101 << i, "done");
            put(hbs_pkg::CMD_SPARE_RD, 16'h0000);
            `CHK("eot", 1'b0, eot)
        end
        $display("test iso done");
        put(hbs_pkg::CMD_STATUS_WR, 16'h0004);
        put(hbs_pkg::CMD_SPARE_WR, 16'h1234);
        put(hbs_pkg::CMD_RESET_WR, 16'h00f5, 1);
        `CHK("srst", 1'b0, srst)
        rd(hbs_pkg::CMD_SPARE_RD, 16'h1234, "spare");
        put(hbs_pkg::CMD_RESET_WR, hbs_pkg::RESET_KEY_VALUE, 1);
        `CHK("srst", 1'b1, srst)
        put(hbs_pkg::CMD_SPARE_RD, 16'h0000, 1);
        `CHK("ien", 1'b0, ien)
        rd(hbs_pkg::CMD_SPARE_RD, 16'h0000, "spare");
        rd(hbs_pkg::CMD_STATUS_RD, 16'h0000, "status");
        $display("test soft reset done");
        stop_test();
    end
    // Watchdog
    initial begin
        #(8 * 2000);
        error_cnt++;
        stop_test();
    end
endmodule : tb_hbs_buffer_status_regs
